// >>> hw/gpio1_output_source_mux.sv
// pin one output control register with apb access and its source multiplexer
//
// How it works
// - control register at index 0x11 (byte 0x44), resets to 0x00, output off.
// - bit 0 enables the pin output; clear leaves it disabled.
// - bit 1 holds a software level driven when the local value is chosen.
// - bits 4:2 pick rx port 0-3, device status 100, tx 110; others reserved.
// - rx source, select 000-011 drives remote pin 0-3 of that port.
// - rx source, select 100 lock, 101 pass, 110 frame valid, 111 line valid.
// - status source, 010 and of enabled locks, 011 and of enabled passes.
// - status source, 100 drives internal frame sync; 101-111 reserved.
// - tx source, 000 and, 001 or, of pass over selected rx ports.
// - tx source, 011 drives line valid while a line is sent.
// - tx source, 100 synchronized flag, 101 tx interrupt, 110-111 reserved.
// - status source, 000 drives the locally written level bit.
// - status source, 001 or of enabled locks.
// - tx source, 010 drives frame valid while a frame is sent.
`timescale 1ns/1ps
`include "gpio1_mux_params.svh"

module gpio1_output_source_mux (
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_ARST_N,
   // apb slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   input  wire logic [3:0]  I_PSTRB,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // receive port status, port n in bit n, remote pins of port n in bits 4n+3:4n
   input  wire logic [15:0] I_RX_REMOTE_GPIO,
   input  wire logic [3:0]  I_RX_LOCK,
   input  wire logic [3:0]  I_RX_PASS,
   input  wire logic [3:0]  I_RX_FRAME_VALID,
   input  wire logic [3:0]  I_RX_LINE_VALID,
   input  wire logic [3:0]  I_RX_PORT_ENABLE,
   // device status
   input  wire logic        I_INTERNAL_FRAME_SYNC,
   // transmit port status
   input  wire logic [3:0]  I_TX_PORT_SELECT,
   input  wire logic        I_TX_FRAME_VALID,
   input  wire logic        I_TX_LINE_VALID,
   input  wire logic        I_TX_SYNCED,
   input  wire logic        I_TX_INTERRUPT,
   // pin
   output logic             O_PIN_LEVEL,
   output logic             O_PIN_OE
);

   gpio1_mux_pkg::mux_state_s st;
   gpio1_mux_pkg::mux_state_s next_st;

   logic                 pin_output_enable;
   logic                 local_output_level;
   gpio1_mux_pkg::code_t output_source_select;
   gpio1_mux_pkg::code_t output_signal_select;
   logic [3:0]           port_pick;
   logic                 lock_all;
   logic                 lock_any;
   logic                 pass_all;
   logic                 tx_pass_all;
   logic                 tx_pass_any;
   logic                 source_value;
   logic                 setup_phase;
   logic                 access_done;
   logic                 addr_hit;

   assign pin_output_enable    = st.ctrl[`EN_BIT];
   assign local_output_level   = st.ctrl[`VAL_BIT];
   assign output_source_select = st.ctrl[`SRC_MSB:`SRC_LSB];
   assign output_signal_select = st.ctrl[`SEL_MSB:`SEL_LSB];

   assign setup_phase = I_PSEL && !I_PENABLE;
   assign access_done = I_PSEL && I_PENABLE && st.pready;
   assign addr_hit    = (I_PADDR == `PIN_CTL_ADDR);

   for (genvar p = 0; p < 4; p++) begin : g_port
      port_signal_pick u_pick (
         .i_remote_gpio (I_RX_REMOTE_GPIO[4*p +: 4]),
         .i_lock        (I_RX_LOCK[p]),
         .i_pass        (I_RX_PASS[p]),
         .i_frame_valid (I_RX_FRAME_VALID[p]),
         .i_line_valid  (I_RX_LINE_VALID[p]),
         .i_sel         (output_signal_select),
         .o_pick        (port_pick[p])
      );
   end

   port_status_reduce u_lock (
      .i_status (I_RX_LOCK),
      .i_mask   (I_RX_PORT_ENABLE),
      .o_all    (lock_all),
      .o_any    (lock_any)
   );

   port_status_reduce u_pass (
      .i_status (I_RX_PASS),
      .i_mask   (I_RX_PORT_ENABLE),
      .o_all    (pass_all),
      .o_any    ()
   );

   port_status_reduce u_tx_pass (
      .i_status (I_RX_PASS),
      .i_mask   (I_TX_PORT_SELECT),
      .o_all    (tx_pass_all),
      .o_any    (tx_pass_any)
   );

   // source and select decode; reserved codes give a low level
   always_comb begin
      source_value = 1'b0;
      if (!output_source_select[2]) begin
         source_value = port_pick[output_source_select[1:0]];
      end else if (output_source_select == `SRC_STATUS) begin
         unique case (output_signal_select)
            `SEL_DEV_LOCAL:    source_value = local_output_level;
            `SEL_DEV_LOCK_OR:  source_value = lock_any;
            `SEL_DEV_LOCK_AND: source_value = lock_all;
            `SEL_DEV_PASS_AND: source_value = pass_all;
            `SEL_DEV_FSYNC:    source_value = I_INTERNAL_FRAME_SYNC;
            default:           source_value = 1'b0;
         endcase
      end else if (output_source_select == `SRC_TX) begin
         unique case (output_signal_select)
            `SEL_TX_PASS_AND:  source_value = tx_pass_all;
            `SEL_TX_PASS_OR:   source_value = tx_pass_any;
            `SEL_TX_FV:        source_value = I_TX_FRAME_VALID;
            `SEL_TX_LV:        source_value = I_TX_LINE_VALID;
            `SEL_TX_SYNCED:    source_value = I_TX_SYNCED;
            `SEL_TX_IRQ:       source_value = I_TX_INTERRUPT;
            default:           source_value = 1'b0;
         endcase
      end
   end

   always_comb begin
      next_st = st;
      // one wait-free access: ready raised on the setup edge, dropped after
      next_st.pready  = 1'b0;
      next_st.pslverr = `APB_OK;
      if (setup_phase) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = addr_hit ? `APB_OK : `APB_ERR;
         next_st.prdata  = `RDATA_ZERO;
         if (addr_hit && !I_PWRITE) begin
            next_st.prdata = {24'h00_0000, st.ctrl};
         end
      end
      // register write, low byte lane only
      if (access_done && I_PWRITE && addr_hit && I_PSTRB[0]) begin
         next_st.ctrl = I_PWDATA[7:0];
      end
      next_st.pin_oe = pin_output_enable;
      next_st.pin_level = pin_output_enable && source_value;
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         st.ctrl      <= `PIN_CTL_RESET;
         st.prdata    <= `RDATA_ZERO;
         st.pready    <= 1'b0;
         st.pslverr   <= `APB_OK;
         st.pin_level <= 1'b0;
         st.pin_oe    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign O_PRDATA    = st.prdata;
   assign O_PREADY    = st.pready;
   assign O_PSLVERR   = st.pslverr;
   assign O_PIN_LEVEL = st.pin_level;
   assign O_PIN_OE    = st.pin_oe;

   // checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);

   sequence s_setup;
      I_PSEL && !I_PENABLE;
   endsequence

   sequence s_write_hit;
      I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && addr_hit && I_PSTRB[0];
   endsequence

   sequence s_access;
      I_PSEL && I_PENABLE && O_PREADY;
   endsequence

   logic on_rx;
   logic on_dev;
   logic on_tx;
   assign on_rx  = pin_output_enable && !output_source_select[2];
   assign on_dev = pin_output_enable && (output_source_select == `SRC_STATUS);
   assign on_tx  = pin_output_enable && (output_source_select == `SRC_TX);

   a_ctrl_after_reset: assert property ($rose(I_ARST_N) |-> st.ctrl == 8'h00)
      else $error("control register not zero after reset");

   a_ctrl_write_lands: assert property (s_write_hit |=> st.ctrl == $past(I_PWDATA[7:0]))
      else $error("control write not stored");

   a_apb_one_wait: assert property (s_setup |=> O_PREADY ##1 !O_PREADY)
      else $error("apb ready not one cycle after setup");

   a_read_back: assert property (s_setup ##0 (!I_PWRITE && addr_hit)
                                 |=> O_PRDATA == {24'h00_0000, $past(st.ctrl)})
      else $error("control read data wrong");

   a_oe_follows_en: assert property (pin_output_enable |=> O_PIN_OE)
      else $error("pin not enabled");

   a_disabled_quiet: assert property (!pin_output_enable |=> !O_PIN_OE && !O_PIN_LEVEL)
      else $error("pin driven while disabled");

   a_rx_remote_pin: assert property (on_rx && !output_signal_select[2]
      |=> O_PIN_LEVEL == $past(I_RX_REMOTE_GPIO[{output_source_select[1:0],
                                                 output_signal_select[1:0]}]))
      else $error("remote pin value not forwarded");

   a_rx_lock_pick: assert property (on_rx && output_signal_select == `SEL_RX_LOCK
      |=> O_PIN_LEVEL == $past(I_RX_LOCK[output_source_select[1:0]]))
      else $error("port lock not driven");

   a_rx_line_pick: assert property (on_rx && output_signal_select == `SEL_RX_LV
      |=> O_PIN_LEVEL == $past(I_RX_LINE_VALID[output_source_select[1:0]]))
      else $error("port line valid not driven");

   a_dev_local: assert property (on_dev && output_signal_select == `SEL_DEV_LOCAL
      |=> O_PIN_LEVEL == $past(local_output_level))
      else $error("local level not driven");

   a_dev_lock_or: assert property (on_dev && output_signal_select == `SEL_DEV_LOCK_OR
      |=> O_PIN_LEVEL == $past(|(I_RX_LOCK & I_RX_PORT_ENABLE)))
      else $error("or of locks wrong");

   a_dev_pass_and: assert property (on_dev && output_signal_select == `SEL_DEV_PASS_AND
      |=> O_PIN_LEVEL == $past((|I_RX_PORT_ENABLE)
                               && (&(I_RX_PASS | ~I_RX_PORT_ENABLE))))
      else $error("and of passes wrong");

   a_dev_fsync: assert property (on_dev && output_signal_select == `SEL_DEV_FSYNC
      |=> O_PIN_LEVEL == $past(I_INTERNAL_FRAME_SYNC))
      else $error("frame sync not driven");

   a_dev_reserved: assert property (on_dev && output_signal_select > `SEL_DEV_FSYNC
      |=> !O_PIN_LEVEL)
      else $error("reserved status code drives high");

   a_src_reserved: assert property (pin_output_enable && output_source_select[2]
      && output_source_select[0] |=> !O_PIN_LEVEL)
      else $error("reserved source drives high");

   a_tx_pass_or: assert property (on_tx && output_signal_select == `SEL_TX_PASS_OR
      |=> O_PIN_LEVEL == $past(|(I_RX_PASS & I_TX_PORT_SELECT)))
      else $error("tx or of passes wrong");

   a_tx_frame: assert property (on_tx && output_signal_select == `SEL_TX_FV
      |=> O_PIN_LEVEL == $past(I_TX_FRAME_VALID))
      else $error("tx frame valid not driven");

   a_tx_line: assert property (on_tx && output_signal_select == `SEL_TX_LV
      |=> O_PIN_LEVEL == $past(I_TX_LINE_VALID))
      else $error("tx line valid not driven");

   a_tx_irq: assert property (on_tx && output_signal_select == `SEL_TX_IRQ
      |=> O_PIN_LEVEL == $past(I_TX_INTERRUPT))
      else $error("tx interrupt not driven");

   a_rx_pass_pick: assert property (on_rx && output_signal_select == `SEL_RX_PASS
      |=> O_PIN_LEVEL == $past(I_RX_PASS[output_source_select[1:0]]))
      else $error("port pass not driven");

   a_rx_frame_pick: assert property (on_rx && output_signal_select == `SEL_RX_FV
      |=> O_PIN_LEVEL == $past(I_RX_FRAME_VALID[output_source_select[1:0]]))
      else $error("port frame valid not driven");

   a_dev_lock_and: assert property (on_dev && output_signal_select == `SEL_DEV_LOCK_AND
      |=> O_PIN_LEVEL == $past((|I_RX_PORT_ENABLE)
                               && ((I_RX_LOCK & I_RX_PORT_ENABLE) == I_RX_PORT_ENABLE)))
      else $error("and of locks wrong");

   a_tx_pass_and: assert property (on_tx && output_signal_select == `SEL_TX_PASS_AND
      |=> O_PIN_LEVEL == $past((|I_TX_PORT_SELECT)
                               && ((I_RX_PASS & I_TX_PORT_SELECT) == I_TX_PORT_SELECT)))
      else $error("tx and of passes wrong");

   a_tx_synced: assert property (on_tx && output_signal_select == `SEL_TX_SYNCED
      |=> O_PIN_LEVEL == $past(I_TX_SYNCED))
      else $error("tx synchronized flag not driven");

   a_tx_reserved: assert property (on_tx && output_signal_select[2] && output_signal_select[1]
      |=> !O_PIN_LEVEL)
      else $error("reserved tx code drives high");

   a_err_unmapped: assert property (s_setup ##0 !addr_hit
      |=> O_PSLVERR && O_PRDATA == `RDATA_ZERO)
      else $error("unmapped access not refused");

   a_err_hit_clear: assert property (s_setup ##0 addr_hit |=> !O_PSLVERR)
      else $error("mapped access flagged as error");

   a_write_miss_keeps: assert property (s_access ##0 (I_PWRITE && !(addr_hit && I_PSTRB[0]))
      |=> $stable(st.ctrl))
      else $error("refused write changed control");

   a_ready_no_idle: assert property (!I_PSEL |=> !O_PREADY)
      else $error("ready raised without a transfer");

   a_prdata_holds: assert property (!(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA))
      else $error("read data moved outside setup");

   a_pin_reset_zero: assert property ($rose(I_ARST_N) |-> !O_PIN_OE && !O_PIN_LEVEL && !O_PREADY)
      else $error("outputs not zero after reset");

   a_level_needs_en: assert property (O_PIN_LEVEL |-> O_PIN_OE)
      else $error("pin level high while not driven");

endmodule : gpio1_output_source_mux

// >>> hw/port_signal_pick.sv
// one receive port: picks a forwarded pin or a status signal by select code
`timescale 1ns/1ps
`include "gpio1_mux_params.svh"

module port_signal_pick (
   // port signals
   input  wire logic [3:0]            i_remote_gpio,
   input  wire logic                  i_lock,
   input  wire logic                  i_pass,
   input  wire logic                  i_frame_valid,
   input  wire logic                  i_line_valid,
   // selection
   input  wire gpio1_mux_pkg::code_t  i_sel,
   // result
   output logic                       o_pick
);

   always_comb begin
      unique case (i_sel)
         `SEL_RX_LOCK: o_pick = i_lock;
         `SEL_RX_PASS: o_pick = i_pass;
         `SEL_RX_FV:   o_pick = i_frame_valid;
         `SEL_RX_LV:   o_pick = i_line_valid;
         default:      o_pick = i_remote_gpio[i_sel[1:0]];
      endcase
   end

endmodule : port_signal_pick

// >>> hw/port_status_reduce.sv
// and / or of a status vector over the ports that a mask admits
`timescale 1ns/1ps

module port_status_reduce (
   // status and mask
   input  wire logic [3:0] i_status,
   input  wire logic [3:0] i_mask,
   // reductions
   output logic            o_all,
   output logic            o_any
);

   // no admitted port gives all low, so an idle hub never reports good
   always_comb begin
      o_all = (|i_mask) && (&(i_status | ~i_mask));
      o_any = |(i_status & i_mask);
   end

endmodule : port_status_reduce

// >>> inc/gpio1_mux_params.svh
// register map, field positions and select codes of the pin one output control
`ifndef GPIO1_MUX_PARAMS_SVH
`define GPIO1_MUX_PARAMS_SVH

// register index as printed, byte address is four times it
`define PIN_CTL_INDEX     12'h011
`define PIN_CTL_ADDR      12'h044
`define PIN_CTL_RESET     8'h00

// field positions
`define EN_BIT            0
`define VAL_BIT           1
`define SRC_LSB           2
`define SRC_MSB           4
`define SEL_LSB           5
`define SEL_MSB           7

// source codes
`define SRC_STATUS        3'h4
`define SRC_TX            3'h6

// select codes, receive port source
`define SEL_RX_LOCK       3'h4
`define SEL_RX_PASS       3'h5
`define SEL_RX_FV         3'h6
`define SEL_RX_LV         3'h7

// select codes, device status source
`define SEL_DEV_LOCAL     3'h0
`define SEL_DEV_LOCK_OR   3'h1
`define SEL_DEV_LOCK_AND  3'h2
`define SEL_DEV_PASS_AND  3'h3
`define SEL_DEV_FSYNC     3'h4

// select codes, transmit port source
`define SEL_TX_PASS_AND   3'h0
`define SEL_TX_PASS_OR    3'h1
`define SEL_TX_FV         3'h2
`define SEL_TX_LV         3'h3
`define SEL_TX_SYNCED     3'h4
`define SEL_TX_IRQ        3'h5

// apb answer values
`define APB_OK            1'h0
`define APB_ERR           1'h1
`define RDATA_ZERO        32'h0000_0000

`endif

// >>> inc/gpio1_mux_pkg.sv
// types of the pin one output source multiplexer
package gpio1_mux_pkg;

   typedef logic [2:0] code_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        pin_level;
      logic        pin_oe;
   } mux_state_s;

endpackage : gpio1_mux_pkg

// >>> sim/gpio1_output_source_mux_test.sv
// self-checking bench of the pin one output source multiplexer
`timescale 1ns/1ps

module gpio1_output_source_mux_test;
   logic        clk, arst_n, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, lock, pass, fv, lv, en, tsel;
   logic        pready, pslverr, lvl, oe, pin, err;
   logic        fsync, tfv, tlv, synced, irq;
   logic [15:0] rgpio;
   int          fails, num_checks;

   gpio1_output_source_mux dut (
      .I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_RX_REMOTE_GPIO(rgpio), .I_RX_LOCK(lock), .I_RX_PASS(pass),
      .I_RX_FRAME_VALID(fv), .I_RX_LINE_VALID(lv), .I_RX_PORT_ENABLE(en),
      .I_INTERNAL_FRAME_SYNC(fsync), .I_TX_PORT_SELECT(tsel),
      .I_TX_FRAME_VALID(tfv), .I_TX_LINE_VALID(tlv), .I_TX_SYNCED(synced),
      .I_TX_INTERRUPT(irq), .O_PIN_LEVEL(lvl), .O_PIN_OE(oe));

   pin_reader board (.i_level(lvl), .i_oe(oe), .o_pin(pin));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         give_verdict();
      end
   endtask : apb

   // four status patterns in inverse pairs, so a stuck pick or a swapped and/or shows
   task automatic set_status(input logic inv, input logic alt);
      @(posedge clk);
      rgpio <= {16{inv}} ^ (alt ? 16'hc3a5 : 16'h5a3c);
      lock <= {4{inv}} ^ (alt ? 4'h1 : 4'h6);
      pass <= {4{inv}} ^ (alt ? 4'hf : 4'hb);
      fv <= {4{inv}} ^ (alt ? 4'h3 : 4'h9);
      lv <= {4{inv}} ^ (alt ? 4'ha : 4'h4);
      en <= {4{inv}} ^ 4'h6;
      tsel <= {4{inv}} ^ (alt ? 4'h5 : 4'h3);
      fsync <= ~inv;
      tfv <= ~inv;
      tlv <= inv;
      synced <= ~inv;
      irq <= inv;
   endtask : set_status

   function automatic logic exp_pin(input logic [7:0] c);
      logic [2:0] s, r;
      s = c[7:5];
      r = c[4:2];
      if (!c[0]) return 1'b0;
      if (!r[2]) begin
         case (s)
            3'h4: return lock[r[1:0]];
            3'h5: return pass[r[1:0]];
            3'h6: return fv[r[1:0]];
            3'h7: return lv[r[1:0]];
            default: return rgpio[{r[1:0], s[1:0]}];
         endcase
      end
      if (r == 3'h4) begin
         case (s)
            3'h0: return c[1];
            3'h1: return |(lock & en);
            3'h2: return en != 4'h0 && (lock & en) == en;
            3'h3: return en != 4'h0 && (pass & en) == en;
            3'h4: return fsync;
            default: return 1'b0;
         endcase
      end
      if (r == 3'h6) begin
         case (s)
            3'h0: return tsel != 4'h0 && (pass & tsel) == tsel;
            3'h1: return |(pass & tsel);
            3'h2: return tfv;
            3'h3: return tlv;
            3'h4: return synced;
            3'h5: return irq;
            default: return 1'b0;
         endcase
      end
      return 1'b0;
   endfunction : exp_pin

   task automatic reset_and_map();
      apb(1'b0, 12'h044, 32'h0);
      check("ctrl reset", rd, 32'h0000_0000);
      check("reset err", {31'h0, err}, 32'h0);
      check("reset oe", {31'h0, oe}, 32'h0);
      apb(1'b1, 12'h044, 32'hffff_ffff);
      apb(1'b0, 12'h044, 32'h0);
      check("ctrl rw", rd, 32'h0000_00ff);
      check("hit err", {31'h0, err}, 32'h0);
      pstrb <= 4'h0;
      apb(1'b1, 12'h044, 32'h0000_0000);
      pstrb <= 4'hf;
      apb(1'b0, 12'h040, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, 12'h040, 32'h0000_0000);
      check("unmapped wr err", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h044, 32'h0);
      check("strobe off", rd, 32'h0000_00ff);
   endtask : reset_and_map

   // every source and select code, enabled then disabled
   task automatic sweep(input logic en_bit);
      logic [7:0] c;
      for (int k = 0; k < 64; k++) begin
         c = {k[5:0], k[0] ^ k[3], en_bit};
         apb(1'b1, 12'h044, {24'h0, c});
         for (int v = 0; v < 4; v++) begin
            set_status(v[0], v[1]);
            repeat (2) @(posedge clk);
            #1;
            check("pin level", {31'h0, lvl}, {31'h0, exp_pin(c)});
            check("pin oe", {31'h0, oe}, {31'h0, en_bit});
            check("board pin", {31'h0, pin}, {31'h0, exp_pin(c)});
         end
      end
   endtask : sweep

   // second reset in mid-run, held over three clocks, drops the pin and clears the register
   task automatic reset_midrun();
      apb(1'b1, 12'h044, 32'h0000_00a5);
      repeat (2) @(posedge clk);
      check("oe before reset", {31'h0, oe}, 32'h1);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      check("oe in reset", {31'h0, oe}, 32'h0);
      check("level in reset", {31'h0, lvl}, 32'h0);
      arst_n <= 1'b1;
      apb(1'b0, 12'h044, 32'h0);
      check("ctrl after reset", rd, 32'h0000_0000);
      check("oe after reset", {31'h0, oe}, 32'h0);
   endtask : reset_midrun

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      fails = 0; num_checks = 0;
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hf; rgpio = 16'h0;
      lock = 4'h0; pass = 4'h0; fv = 4'h0; lv = 4'h0; en = 4'h0; tsel = 4'h0;
      fsync = 1'b0; tfv = 1'b0; tlv = 1'b0; synced = 1'b0; irq = 1'b0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      reset_and_map();
      sweep(1'b1);
      reset_midrun();
      sweep(1'b0);
      give_verdict();
   end
endmodule : gpio1_output_source_mux_test

// >>> sim/pin_reader.sv
// board side model of the logic reading pin one
`timescale 1ns/1ps

module pin_reader (
   // pin
   input  wire logic i_level,
   input  wire logic i_oe,
   // level seen by the board
   output logic      o_pin
);
   // released pin falls to the board pull-down, never keeps the last value
   assign o_pin = i_oe ? i_level : 1'b0;
endmodule : pin_reader
